// ---- shared/event_pkg.sv ----
`default_nettype none
package event_pkg;
  localparam int          EV_W        = 32;
  localparam int          CNT_W       = 8;
  localparam int          NSRC        = 9;
  // bit index = 31 minus the big-endian field position
  localparam int          BIT_TAG     = 0;
  localparam int          BIT_STALL   = 1;
  localparam int          BIT_CMDQ    = 3;
  localparam int          BIT_INMB    = 4;
  localparam int          BIT_DEC     = 5;
  localparam int          BIT_OUTIMB  = 6;
  localparam int          BIT_OUTMB   = 7;
  localparam int          BIT_SIG2    = 8;
  localparam int          BIT_SIG1    = 9;
  localparam int          BIT_RESV    = 10;
  localparam int          BIT_ATTN    = 11;
  localparam int          BIT_MSYNC   = 12;
  localparam logic [31:0] EV_VALID    = 32'h00001FFB;
  localparam logic [31:0] PEND_RESET  = 32'h00000000;
  localparam logic [31:0] MASK_RESET  = 32'h00000000;
  localparam logic [31:0] DEC_RESET   = 32'h00000000;
  localparam logic [7:0]  CNT_ONE     = 8'h01;
  // source order: tag, lsn, cmdq, inmb, outmb, outimb, sig2, sig1, msync
  localparam int          SRC_BIT [0:NSRC-1] = '{BIT_TAG, BIT_STALL, BIT_CMDQ, BIT_INMB,
                                                 BIT_OUTMB, BIT_OUTIMB, BIT_SIG2, BIT_SIG1,
                                                 BIT_MSYNC};
  localparam int          SRC_MSYNC   = 8;
  localparam int          DEC_INTERVAL_NS = 80;
  localparam int          CLK_MHZ     = 200;
  localparam int          DEC_TICK_CYCLES = (DEC_INTERVAL_NS * CLK_MHZ) / 1000;
  localparam int          TICK_W      = 8;

  typedef struct packed {
    logic [CNT_W-1:0] tag;
    logic [CNT_W-1:0] lsn;
    logic [CNT_W-1:0] cmdq;
    logic [CNT_W-1:0] inmb;
    logic [CNT_W-1:0] outmb;
    logic [CNT_W-1:0] outimb;
    logic [CNT_W-1:0] sig2;
    logic [CNT_W-1:0] sig1;
    logic [CNT_W-1:0] msync;
  } counts_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } chan_wr_s;
endpackage
`default_nettype wire

// ---- core/event_rise.sv ----
`default_nettype none
module event_rise (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic zero,
  input  wire logic hit,
  output logic      rise
);
  logic prev_zero_reg;

  // remembers whether the count stood at zero last cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_zero_reg <= 1'b1;
    end else begin
      prev_zero_reg <= zero;
    end
  end

  assign rise = prev_zero_reg & hit;
endmodule
`default_nettype wire

// ---- core/coprocessor_event_detect.sv ----
`default_nettype none
module coprocessor_event_detect
  import event_pkg::*;
(
  input  wire logic     CLK,
  input  wire logic     RST,
  input  wire counts_s  COUNTS,
  input  wire chan_wr_s MASK_WR,
  input  wire chan_wr_s ACK_WR,
  input  wire chan_wr_s RESTORE_WR,
  input  wire chan_wr_s DEC_LOAD,
  input  wire logic     STAT_RD,
  input  wire logic     PRIV_WR,
  input  wire logic     PRIV_ATTN,
  input  wire logic     RES_LOST,
  input  wire logic     LIST_STALL_DONE,
  output logic [31:0]   STAT_DATA,
  output logic          STAT_COUNT,
  output logic [31:0]   MASK_OUT,
  output logic [31:0]   PEND_OUT,
  output logic [31:0]   DEC_COUNT,
  output logic          DEC_RUNNING,
  output logic          LIST_SUSPEND
);
  logic [CNT_W-1:0]  src_cnt [0:NSRC-1];
  logic [NSRC-1:0]   src_rise;
  logic [31:0]       ev_set;
  logic [31:0]       ack_clr;
  logic [31:0]       pend_reg;
  logic [31:0]       mask_reg;
  logic [31:0]       stat_reg;
  logic [31:0]       dec_reg;
  logic              msb_prev_reg;
  logic              dec_run_reg;
  logic [TICK_W-1:0] tick_cnt_reg;
  logic              tick;
  logic              dec_set;
  logic              suspend_reg;
  logic              dec_stop;

  function automatic logic nonzero(input logic [CNT_W-1:0] c);
    return c != '0;
  endfunction

  assign src_cnt[0] = COUNTS.tag;
  assign src_cnt[1] = COUNTS.lsn;
  assign src_cnt[2] = COUNTS.cmdq;
  assign src_cnt[3] = COUNTS.inmb;
  assign src_cnt[4] = COUNTS.outmb;
  assign src_cnt[5] = COUNTS.outimb;
  assign src_cnt[6] = COUNTS.sig2;
  assign src_cnt[7] = COUNTS.sig1;
  assign src_cnt[8] = COUNTS.msync;

  // zero-to-nonzero detectors, sync source needs exactly one
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      event_rise u_rise (
        .clk  (CLK),
        .rst  (RST),
        .zero (!nonzero(src_cnt[g])),
        .hit  ((g == SRC_MSYNC) ? (src_cnt[g] == CNT_ONE) : nonzero(src_cnt[g])),
        .rise (src_rise[g])
      );
    end
  endgenerate

  // decrementer interval divider, restarted by a load
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tick_cnt_reg <= '0;
    end else if (DEC_LOAD.valid || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  assign tick = (tick_cnt_reg == TICK_W'(DEC_TICK_CYCLES - 1));

  // stops when its event is acknowledged while disabled
  assign dec_stop = ACK_WR.valid && ACK_WR.data[BIT_DEC] && !mask_reg[BIT_DEC];

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dec_run_reg <= 1'b0;
    end else if (DEC_LOAD.valid) begin
      dec_run_reg <= 1'b1;
    end else if (dec_stop) begin
      dec_run_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dec_reg <= DEC_RESET;
    end else if (DEC_LOAD.valid) begin
      dec_reg <= DEC_LOAD.data;
    end else if (dec_run_reg && tick) begin
      dec_reg <= dec_reg - 32'h00000001;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      msb_prev_reg <= 1'b0;
    end else begin
      msb_prev_reg <= dec_reg[31];
    end
  end

  // also fires straight after a load that raises the top bit
  assign dec_set = dec_reg[31] && !msb_prev_reg;

  // gather all event sources into one set vector
  always_comb begin
    ev_set = '0;
    for (int i = 0; i < NSRC; i++) begin
      ev_set[SRC_BIT[i]] = src_rise[i];
    end
    ev_set[BIT_DEC]  = dec_set;
    ev_set[BIT_RESV] = RES_LOST;
    ev_set[BIT_ATTN] = PRIV_WR && PRIV_ATTN;
    ev_set           = ev_set & EV_VALID;
  end

  assign ack_clr = ACK_WR.valid ? ACK_WR.data : '0;

  // pending word, mask independent, set beats acknowledge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pend_reg <= PEND_RESET;
    end else if (RESTORE_WR.valid) begin
      pend_reg <= (RESTORE_WR.data & EV_VALID) | ev_set;
    end else begin
      pend_reg <= (pend_reg & ~ack_clr) | ev_set;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mask_reg <= MASK_RESET;
    end else if (MASK_WR.valid) begin
      mask_reg <= MASK_WR.data & EV_VALID;
    end
  end

  // status sampled at read time from current mask and pending
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      stat_reg <= '0;
    end else if (STAT_RD) begin
      stat_reg <= pend_reg & mask_reg;
    end
  end

  // list processing held after a stall-flagged element
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      suspend_reg <= 1'b0;
    end else if (LIST_STALL_DONE) begin
      suspend_reg <= 1'b1;
    end else if (ack_clr[BIT_STALL]) begin
      suspend_reg <= 1'b0;
    end
  end

  assign STAT_COUNT   = |(pend_reg & mask_reg);
  assign STAT_DATA    = stat_reg;
  assign MASK_OUT     = mask_reg;
  assign PEND_OUT     = pend_reg;
  assign DEC_COUNT    = dec_reg;
  assign DEC_RUNNING  = dec_run_reg;
  assign LIST_SUSPEND = suspend_reg;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  cmdq_event_a: assert property (
    ($past(COUNTS.cmdq) == '0 && COUNTS.cmdq != '0) |=> pend_reg[BIT_CMDQ])
    else $error("queue available event missed");

  list_suspend_a: assert property (
    LIST_STALL_DONE |=> LIST_SUSPEND)
    else $error("list not suspended after stall element");

  stall_event_a: assert property (
    ($past(COUNTS.lsn) == '0 && COUNTS.lsn != '0) |=> pend_reg[BIT_STALL])
    else $error("stall notify event missed");

  tag_event_a: assert property (
    ($past(COUNTS.tag) == '0 && COUNTS.tag != '0) |=> pend_reg[BIT_TAG])
    else $error("tag status event missed");

  inmb_event_a: assert property (
    ($past(COUNTS.inmb) == '0 && COUNTS.inmb != '0) |=> pend_reg[BIT_INMB])
    else $error("inbound mailbox event missed");

  dec_msb_a: assert property (
    $rose(dec_reg[31]) |=> pend_reg[BIT_DEC])
    else $error("decrementer event missed");

  dec_load_a: assert property (
    (DEC_LOAD.valid && !dec_reg[31] && DEC_LOAD.data[31]) |-> ##2 pend_reg[BIT_DEC])
    else $error("load did not signal at once");

  dec_wrap_a: assert property (
    (dec_run_reg && tick && dec_reg == '0 && !DEC_LOAD.valid) |=> dec_reg == 32'hFFFFFFFF)
    else $error("decrementer did not wrap");

  outmb_event_a: assert property (
    ($past(COUNTS.outmb) == '0 && COUNTS.outmb != '0) |=> pend_reg[BIT_OUTMB])
    else $error("outbound mailbox event missed");

  resv_lost_a: assert property (
    RES_LOST |=> pend_reg[BIT_RESV])
    else $error("reservation lost event missed");

  attn_write_a: assert property (
    (PRIV_WR && PRIV_ATTN) |=> pend_reg[BIT_ATTN])
    else $error("attention event missed");

  msync_only_one_a: assert property (
    ($past(COUNTS.msync) == '0 && COUNTS.msync > CNT_ONE) |=> !pend_reg[BIT_MSYNC] ||
      $past(pend_reg[BIT_MSYNC]) || $past(RESTORE_WR.valid))
    else $error("sync event set on jump above one");

  ack_clear_a: assert property (
    (ACK_WR.valid && ACK_WR.data[BIT_TAG] && !ev_set[BIT_TAG] && !RESTORE_WR.valid)
      |=> !pend_reg[BIT_TAG])
    else $error("acknowledge did not clear");

  stat_sample_a: assert property (
    STAT_RD |=> STAT_DATA == ($past(pend_reg) & $past(mask_reg)))
    else $error("status read not current");

  pend_hold_a: assert property (
    (pend_reg[BIT_INMB] && !ack_clr[BIT_INMB] && !RESTORE_WR.valid) |=> pend_reg[BIT_INMB])
    else $error("pending event lost without acknowledge");

  count_gate_a: assert property (
    (mask_reg == '0) |-> !STAT_COUNT)
    else $error("masked event drove status count");

  outimb_event_a: assert property (
    ($past(COUNTS.outimb) == '0 && COUNTS.outimb != '0) |=> pend_reg[BIT_OUTIMB])
    else $error("outbound interrupt mailbox event missed");

  sig2_event_a: assert property (
    ($past(COUNTS.sig2) == '0 && COUNTS.sig2 != '0) |=> pend_reg[BIT_SIG2])
    else $error("signal two event missed");

  sig1_event_a: assert property (
    ($past(COUNTS.sig1) == '0 && COUNTS.sig1 != '0) |=> pend_reg[BIT_SIG1])
    else $error("signal one event missed");

  msync_event_a: assert property (
    ($past(COUNTS.msync) == '0 && COUNTS.msync == CNT_ONE) |=> pend_reg[BIT_MSYNC])
    else $error("sync event missed");

  rise_once_a: assert property (
    ($past(COUNTS.inmb) != '0 && !$past(RST)) |-> !ev_set[BIT_INMB])
    else $error("event set again without leaving zero");

  restore_load_a: assert property (
    RESTORE_WR.valid |=>
      pend_reg == (($past(RESTORE_WR.data) & EV_VALID) | $past(ev_set)))
    else $error("restore did not load pending word");

  mask_write_a: assert property (
    MASK_WR.valid |=> mask_reg == ($past(MASK_WR.data) & EV_VALID))
    else $error("mask write not taken");

  reserved_zero_a: assert property (
    (pend_reg & ~EV_VALID) == '0)
    else $error("reserved pending bit set");

  stat_hold_a: assert property (
    !STAT_RD |=> $stable(STAT_DATA))
    else $error("status word changed without a read");

  attn_quiet_a: assert property (
    (PRIV_WR && !PRIV_ATTN && !pend_reg[BIT_ATTN] && !RESTORE_WR.valid)
      |=> !pend_reg[BIT_ATTN])
    else $error("attention event set without request bit");

  suspend_hold_a: assert property (
    (LIST_SUSPEND && !ack_clr[BIT_STALL]) |=> LIST_SUSPEND)
    else $error("list released without acknowledge");

  dec_restart_a: assert property (
    DEC_LOAD.valid |=> tick_cnt_reg == '0)
    else $error("load did not restart the interval");

  stall_ack_c:   cover property (LIST_SUSPEND ##[1:20] !LIST_SUSPEND);
  dec_wrap_c:    cover property (dec_set && !dec_run_reg ##0 1 or (tick && dec_reg == '0));
  phantom_c:     cover property (STAT_COUNT ##1 ACK_WR.valid ##1 STAT_RD);
  msync_c:       cover property (ev_set[BIT_MSYNC]);
  restore_c:     cover property (RESTORE_WR.valid ##1 STAT_COUNT);
endmodule
`default_nettype wire

// ---- sim/dma_count_model.sv ----
`default_nettype none
module dma_count_model
  import event_pkg::*;
(
  output var counts_s counts
);
  timeunit 1ns;
  timeprecision 100ps;
  // channel counts are levels changed between clock edges
  initial counts = '0;
  task automatic set_count(input int idx, input logic [CNT_W-1:0] val);
    counts[(NSRC-1-idx)*CNT_W +: CNT_W] = val;
  endtask
endmodule
`default_nettype wire

// ---- sim/test_coprocessor_event_detect.sv ----
`default_nettype none
module test_coprocessor_event_detect;
  timeunit 1ns;
  timeprecision 100ps;
  import event_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  counts_s cnt;
  chan_wr_s mask_wr = '0, ack_wr = '0, rest_wr = '0, dec_ld = '0;
  logic stat_rd = 1'b0, priv_wr = 1'b0, priv_attn = 1'b0, res_lost = 1'b0, stall_done = 1'b0;
  logic [31:0] stat_data, mask_out, pend_out, dec_count;
  logic stat_count, dec_running, list_suspend;
  int num_errors = 0;
  int checks = 0;
  always #2.5 clk = ~clk;
  dma_count_model DMA (.counts(cnt));
  coprocessor_event_detect DUT (
    .CLK(clk), .RST(rst), .COUNTS(cnt), .MASK_WR(mask_wr), .ACK_WR(ack_wr),
    .RESTORE_WR(rest_wr), .DEC_LOAD(dec_ld), .STAT_RD(stat_rd), .PRIV_WR(priv_wr),
    .PRIV_ATTN(priv_attn), .RES_LOST(res_lost), .LIST_STALL_DONE(stall_done),
    .STAT_DATA(stat_data), .STAT_COUNT(stat_count), .MASK_OUT(mask_out),
    .PEND_OUT(pend_out), .DEC_COUNT(dec_count), .DEC_RUNNING(dec_running),
    .LIST_SUSPEND(list_suspend)
  );
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    check32({31'h0, got}, {31'h0, exp});
  endtask
  // one-cycle strobe: 0 mask 1 ack 2 restore 3 load 4 read 5 priv 6 lost 7 stall
  task automatic pulse(input int k, input logic [31:0] d);
    @(negedge clk);
    case (k)
      0: mask_wr = '{1'b1, d};
      1: ack_wr = '{1'b1, d};
      2: rest_wr = '{1'b1, d};
      3: dec_ld = '{1'b1, d};
      4: stat_rd = 1'b1;
      5: begin priv_wr = 1'b1; priv_attn = d[0]; end
      6: res_lost = 1'b1;
      default: stall_done = 1'b1;
    endcase
    @(negedge clk);
    {mask_wr, ack_wr, rest_wr, dec_ld} = '0;
    {stat_rd, priv_wr, priv_attn, res_lost, stall_done} = '0;
  endtask
  task automatic test_sources();
    logic [31:0] b;
    for (int i = 0; i < NSRC; i++) begin
      b = 32'h00000001 << SRC_BIT[i];
      DMA.set_count(i, 8'h01);
      step(2);
      check32(pend_out, b);
      DMA.set_count(i, 8'h02);
      pulse(1, b);
      step(1);
      check32(pend_out, 32'h00000000);
      DMA.set_count(i, 8'h00);
      step(2);
      DMA.set_count(i, 8'h01);
      step(1);
      DMA.set_count(i, 8'h00);
      step(2);
      check32(pend_out, b);
      pulse(1, b);
      step(1);
      check32(pend_out, 32'h00000000);
    end
    DMA.set_count(SRC_MSYNC, 8'h02);
    step(2);
    check32(pend_out, 32'h00000000);
    DMA.set_count(SRC_MSYNC, 8'h00);
  endtask
  task automatic test_misc();
    pulse(6, 0);
    step(1);
    check32(pend_out, 32'h00000001 << BIT_RESV);
    pulse(5, 0);
    step(1);
    check32(pend_out, 32'h00000001 << BIT_RESV);
    pulse(5, 1);
    step(1);
    check32(pend_out, 32'h00000C00);
    pulse(7, 0);
    step(6);
    check1(list_suspend, 1'b1);
    pulse(1, 32'hFFFFFFFF);
    step(1);
    check1(list_suspend, 1'b0);
    pulse(2, 32'hFFFFFFFF);
    step(1);
    check32(pend_out, EV_VALID);
    pulse(1, 32'hFFFFFFFF);
  endtask
  task automatic test_status();
    DMA.set_count(3, 8'h01);
    step(2);
    check1(stat_count, 1'b0);
    pulse(0, 32'hFFFFFFFF);
    check32(mask_out, EV_VALID);
    check1(stat_count, 1'b1);
    pulse(4, 0);
    check32(stat_data, 32'h00000010);
    pulse(1, 32'h00000010);
    DMA.set_count(3, 8'h00);
    step(1);
    check1(stat_count, 1'b0);
    DMA.set_count(3, 8'h01);
    step(2);
    pulse(1, 32'h00000010);
    pulse(4, 0);
    check32(stat_data, 32'h00000000);
    DMA.set_count(3, 8'h00);
  endtask
  task automatic test_dec();
    int n;
    pulse(3, 32'h80000000);
    step(2);
    check32(pend_out, 32'h00000020);
    pulse(1, 32'h00000020);
    pulse(3, 32'h00000000);
    n = 0;
    while (pend_out[BIT_DEC] !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    check1(n == DEC_TICK_CYCLES + 1, 1'b1);
    check32(dec_count, 32'hFFFFFFFF);
    pulse(0, EV_VALID & 32'hFFFFFFDF);
    pulse(1, 32'h00000020);
    step(1);
    check1(dec_running, 1'b0);
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    complete_run();
  end
  initial begin
    step(20);
    rst = 1'b0;
    step(1);
    check32(pend_out | mask_out | stat_data | dec_count, 32'h00000000);
    test_sources();
    test_misc();
    test_status();
    test_dec();
    complete_run();
  end
endmodule
`default_nettype wire
